/* verilog/stepper_cmd_port.sv */
`timescale 1ns/10ps
module stepper_cmd_port
	import stepper_pkg::*;
#(
	parameter int ENABLE_SETUP_CYCLES = ENABLE_SETUP_CYCLES_DEF,
	parameter int REVERSE_CYCLES = REVERSE_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic device_enable_low_pin,
	input wire logic link_clk,
	input wire logic frame_select_low,
	input wire logic serial_command_in,
	output logic serial_response_out,
	output logic serial_response_oe_low,
	input wire logic [1:0] open_load_in,
	input wire logic [3:0] short_supply_in,
	input wire logic [3:0] short_ground_in,
	input wire logic temp_prealarm_in,
	input wire logic thermal_shutdown_in,
	output logic fault_flag_high,
	output logic bridge_one_out_one,
	output logic bridge_one_out_two,
	output logic bridge_two_out_one,
	output logic bridge_two_out_two,
	output logic [1:0] bridge_one_range,
	output logic [1:0] bridge_two_range
);

	localparam logic [TIMER_W-1:0] READY_LAST = TIMER_W'(ENABLE_SETUP_CYCLES - 1);
	localparam logic [TIMER_W-1:0] REV_LAST = TIMER_W'(REVERSE_CYCLES - 1);

	function automatic logic [2:0] cmd_field(input logic [7:0] b, input int idx);
		cmd_field = (idx == 0) ? b[B1_FIELD_LSB +: 3] : b[B2_FIELD_LSB +: 3];
	endfunction

	// AND of identical codes of one level collapses to the code itself
	function automatic logic [1:0] dom_code(input logic any, input logic [1:0] code);
		dom_code = any ? code : ERR_NORMAL;
	endfunction

	frame_link_if lnk();

	logic en_s1_r;
	logic en_s2_r;
	logic csn_s1_r;
	logic csn_s2_r;
	logic csn_s3_r;
	logic [FAULT_W-1:0] flt_s1_r;
	logic [FAULT_W-1:0] flt_s2_r;
	logic [LATCH_W-1:0] latch_r;
	logic [LATCH_W-1:0] latch_nxt;
	logic [TIMER_W-1:0] ready_cnt_r;
	logic ready_r;
	logic standby_r;
	logic [OP_W-1:0] op_r;
	logic [7:0] resp_r;
	logic [CNT_W-1:0] start_r;
	logic oe_low_r;
	logic flag_r;
	logic [2:0] target_r [2];
	logic drive_one_r [2];
	logic drive_two_r [2];
	logic [1:0] range_out_r [2];
	logic link_data_w;

	logic rst_w;
	logic frame_begin_w;
	logic frame_end_w;
	logic [CNT_W-1:0] edges_w;
	logic accept_w;
	logic shutdown_w;
	logic temp_w;
	logic low_any_w;
	logic ground_any_w;
	logic [1:0] err_w;
	logic [7:0] resp_nxt;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en_s1_r <= 1'b1;
			en_s2_r <= 1'b1;
			csn_s1_r <= 1'b1;
			csn_s2_r <= 1'b1;
			csn_s3_r <= 1'b1;
			flt_s1_r <= '0;
			flt_s2_r <= '0;
		end else begin
			en_s1_r <= device_enable_low_pin;
			en_s2_r <= en_s1_r;
			csn_s1_r <= frame_select_low;
			csn_s2_r <= csn_s1_r;
			csn_s3_r <= csn_s2_r;
			flt_s1_r <= {thermal_shutdown_in, temp_prealarm_in, short_ground_in,
				short_supply_in, open_load_in};
			flt_s2_r <= flt_s1_r;
		end
	end

	// enable high holds core in reset
	assign rst_w = sys_rst | en_s2_r;

	////////////////////////////////////////////////////////////////////////
	// Link side runs on the serial clock
	serial_link u_link (
		.link_clk(link_clk),
		.device_enable_low_pin(device_enable_low_pin),
		.frame_select_low(frame_select_low),
		.serial_command_in(serial_command_in),
		.serial_data(link_data_w),
		.lnk(lnk.link)
	);

	// Link counters and bytes are quiet while select is high, so the
	// synchronised select edges mark when they may be read here.
	assign frame_begin_w = csn_s3_r & ~csn_s2_r;
	assign frame_end_w = ~csn_s3_r & csn_s2_r;
	assign edges_w = lnk.edge_cnt - start_r;
	assign shutdown_w = flt_s2_r[F_SHUTDOWN];
	assign temp_w = flt_s2_r[F_PREALARM] | shutdown_w;

	assign accept_w = frame_end_w & ready_r & ~shutdown_w & (edges_w != CNT_RESET)
		& (edges_w[2:0] == ERR_FRAME_MOD);

	////////////////////////////////////////////////////////////////////////
	// ignore frames until setup time elapsed
	always_ff @(posedge clk) begin
		if (rst_w) begin
			ready_cnt_r <= TIMER_RESET;
			ready_r <= 1'b0;
		end else if (!ready_r) begin
			ready_cnt_r <= ready_cnt_r + TIMER_W'(1);
			ready_r <= (ready_cnt_r == READY_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clear on taken byte, new fault wins
	assign latch_nxt = (latch_r & ~{LATCH_W{accept_w}}) | flt_s2_r[LATCH_W-1:0];

	always_ff @(posedge clk) begin
		if (rst_w) begin
			latch_r <= '0;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	// open and supply short share lowest level
	assign low_any_w = |latch_r[F_GROUND_LSB-1:F_OPEN_LSB];
	assign ground_any_w = |latch_r[F_PREALARM-1:F_GROUND_LSB];

	assign err_w = temp_w ? ERR_TEMP :
		ground_any_w ? dom_code(ground_any_w, ERR_GROUND) : dom_code(low_any_w, ERR_LOW);

	////////////////////////////////////////////////////////////////////////
	// frozen at frame start for the link
	assign resp_nxt = standby_r ? RESP_STANDBY : {err_w, op_r};

	always_ff @(posedge clk) begin
		if (rst_w) begin
			resp_r <= RESP_STANDBY;
			start_r <= CNT_RESET;
		end else if (frame_begin_w) begin
			resp_r <= resp_nxt;
			start_r <= lnk.edge_cnt;
		end
	end

	assign lnk.resp_byte = resp_r;
	assign lnk.start_cnt = start_r;

	// last six bits of the chain applied
	always_ff @(posedge clk) begin
		if (rst_w) begin
			op_r <= OP_RESET;
			standby_r <= 1'b1;
		end else if (shutdown_w) begin
			op_r <= OP_RESET;
		end else if (accept_w) begin
			op_r <= lnk.rx_byte[OP_W-1:0];
			standby_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// driven only inside the frame
	always_ff @(posedge clk) begin
		if (rst_w) begin
			oe_low_r <= 1'b1;
			flag_r <= 1'b1;
		end else begin
			oe_low_r <= csn_s2_r;
			flag_r <= err_w[1];
		end
	end

	assign serial_response_oe_low = oe_low_r;
	assign serial_response_out = link_data_w;
	assign fault_flag_high = flag_r;

	////////////////////////////////////////////////////////////////////////
	// Bridges
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bridge
			bridge_state_t state_r;
			logic pol_r;
			logic [TIMER_W-1:0] timer_r;
			logic want_on_w;
			logic want_pol_w;
			logic on_w;

			assign want_on_w = (target_r[gi][2:1] != RANGE_OFF) & ~shutdown_w;
			assign want_pol_w = target_r[gi][0];
			// Drive and range share one qualifier, so an off command cannot split them
			assign on_w = (state_r == BR_ON) & want_on_w;

			always_ff @(posedge clk) begin
				if (rst_w || shutdown_w) begin
					target_r[gi] <= FIELD_RESET;
				end else if (accept_w) begin
					target_r[gi] <= cmd_field(lnk.rx_byte, gi);
				end
			end

			// off first, then reversed after delay
			always_ff @(posedge clk) begin
				if (rst_w) begin
					state_r <= BR_OFF;
					pol_r <= 1'b0;
					timer_r <= TIMER_RESET;
				end else begin
					unique case (state_r)
						BR_OFF: begin
							if (want_on_w) begin
								state_r <= BR_ON;
								pol_r <= want_pol_w;
							end
						end
						BR_ON: begin
							if (!want_on_w) begin
								state_r <= BR_OFF;
							end else if (want_pol_w != pol_r) begin
								state_r <= BR_REVERSE;
								timer_r <= TIMER_RESET;
							end
						end
						BR_REVERSE: begin
							if (!want_on_w) begin
								state_r <= BR_OFF;
							end else if (timer_r == REV_LAST) begin
								state_r <= BR_ON;
								pol_r <= want_pol_w;
							end else begin
								timer_r <= timer_r + TIMER_W'(1);
							end
						end
						default: begin
							state_r <= BR_OFF;
						end
					endcase
				end
			end

			always_ff @(posedge clk) begin
				if (rst_w) begin
					drive_one_r[gi] <= 1'b0;
					drive_two_r[gi] <= 1'b0;
					range_out_r[gi] <= RANGE_OFF;
				end else begin
					drive_one_r[gi] <= on_w & pol_r;
					drive_two_r[gi] <= on_w & ~pol_r;
					range_out_r[gi] <= on_w ? target_r[gi][2:1] : RANGE_OFF;
				end
			end
		end
	endgenerate

	assign bridge_one_out_one = drive_one_r[0];
	assign bridge_one_out_two = drive_two_r[0];
	assign bridge_two_out_one = drive_one_r[1];
	assign bridge_two_out_two = drive_two_r[1];
	assign bridge_one_range = range_out_r[0];
	assign bridge_two_range = range_out_r[1];

endmodule

/* verilog/stepper_pkg.sv */
package stepper_pkg;

	localparam int BYTE_BITS = 8;
	localparam int CNT_W = 8;
	localparam int TIMER_W = 20;
	localparam int FAULT_W = 12;
	localparam int LATCH_W = 10;

	// Clock rate and the two documented times
	localparam int CLK_MHZ = 250;
	localparam int ENABLE_SETUP_US = 30;
	localparam int REVERSE_MS = 1;
	localparam int ENABLE_SETUP_CYCLES_DEF = ENABLE_SETUP_US * CLK_MHZ;
	localparam int REVERSE_CYCLES_DEF = REVERSE_MS * 1000 * CLK_MHZ;

	// Command byte field positions
	localparam int B1_FIELD_LSB = 3;
	localparam int B2_FIELD_LSB = 0;
	localparam int ERR_HI_BIT = 7;
	localparam int OP_W = 6;

	// Fault vector layout after the synchronisers
	localparam int F_OPEN_LSB = 0;
	localparam int F_SUPPLY_LSB = 2;
	localparam int F_GROUND_LSB = 6;
	localparam int F_PREALARM = 10;
	localparam int F_SHUTDOWN = 11;

	localparam logic [1:0] RANGE_OFF = 2'h3;
	localparam logic [1:0] ERR_NORMAL = 2'h3;
	localparam logic [1:0] ERR_LOW = 2'h1;
	localparam logic [1:0] ERR_GROUND = 2'h2;
	localparam logic [1:0] ERR_TEMP = 2'h0;

	localparam logic [7:0] RESP_STANDBY = 8'hff;
	localparam logic [5:0] OP_RESET = 6'h3f;
	localparam logic [2:0] FIELD_RESET = 3'h6;
	localparam logic [2:0] ERR_FRAME_MOD = 3'h0;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
	localparam logic [TIMER_W-1:0] TIMER_RESET = 20'h0_0000;

	typedef enum logic [1:0] {
		BR_OFF = 2'b00,
		BR_ON = 2'b01,
		BR_REVERSE = 2'b10
	} bridge_state_t;

endpackage

/* verilog/frame_link_if.sv */
`timescale 1ns/10ps
interface frame_link_if;
	logic [7:0] rx_byte;
	logic [7:0] edge_cnt;
	logic [7:0] start_cnt;
	logic [7:0] resp_byte;

	modport link (
		output rx_byte,
		output edge_cnt,
		input start_cnt,
		input resp_byte
	);

	modport core (
		input rx_byte,
		input edge_cnt,
		output start_cnt,
		output resp_byte
	);
endinterface

/* verilog/serial_link.sv */
`timescale 1ns/10ps
module serial_link
	import stepper_pkg::*;
(
	input wire logic link_clk,
	input wire logic device_enable_low_pin,
	input wire logic frame_select_low,
	input wire logic serial_command_in,
	output logic serial_data,
	frame_link_if.link lnk
);

	logic [7:0] rx_r;
	logic [CNT_W-1:0] cnt_r;
	logic out_r;
	logic [CNT_W-1:0] rel_w;
	logic past_own_w;
	logic [2:0] resp_idx_w;

	// Count is never cleared per frame: the core snapshots it at frame start,
	// so nothing here depends on an edge outside the frame.
	assign rel_w = cnt_r - lnk.start_cnt;
	assign past_own_w = (rel_w >= CNT_W'(BYTE_BITS - 1));
	assign resp_idx_w = 3'(CNT_W'(BYTE_BITS - 2) - rel_w);

	////////////////////////////////////////////////////////////////////////
	// sample input on rise
	always_ff @(posedge link_clk or posedge device_enable_low_pin) begin
		if (device_enable_low_pin) begin
			rx_r <= 8'h00;
		end else if (!frame_select_low) begin
			rx_r <= {rx_r[6:0], serial_command_in};
		end
	end

	always_ff @(negedge link_clk or posedge device_enable_low_pin) begin
		if (device_enable_low_pin) begin
			cnt_r <= CNT_RESET;
			out_r <= 1'b1;
		end else if (!frame_select_low) begin
			cnt_r <= cnt_r + CNT_W'(1);
			// pass older bits down the chain
			out_r <= past_own_w ? rx_r[7] : lnk.resp_byte[resp_idx_w];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// First bit must stand before any falling edge
	assign serial_data = (rel_w == CNT_RESET) ? lnk.resp_byte[ERR_HI_BIT] : out_r;
	assign lnk.rx_byte = rx_r;
	assign lnk.edge_cnt = cnt_r;

endmodule

/* bench/stepper_cmd_port_properties.sv */
`timescale 1ns/10ps
module stepper_cmd_port_properties
	import stepper_pkg::*;
#(
	parameter int ENABLE_SETUP_CYCLES = 20,
	parameter int REVERSE_CYCLES = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic device_enable_low_pin,
	input wire logic frame_select_low,
	input wire logic temp_prealarm_in,
	input wire logic thermal_shutdown_in,
	input wire logic serial_response_oe_low,
	input wire logic fault_flag_high,
	input wire logic bridge_one_out_one,
	input wire logic bridge_one_out_two,
	input wire logic bridge_two_out_one,
	input wire logic bridge_two_out_two,
	input wire logic [1:0] bridge_one_range,
	input wire logic [1:0] bridge_two_range
);
	wire logic on_one = bridge_one_out_one | bridge_one_out_two;
	wire logic on_two = bridge_two_out_one | bridge_two_out_two;
	wire logic run = !device_enable_low_pin;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	chk_oe_idle_high: assert property (frame_select_low [*4] |-> serial_response_oe_low)
		else $error("output driven while deselected");
	chk_polarity_one_hot: assert property (!(on_one && bridge_one_out_one && bridge_one_out_two))
		else $error("bridge one driven both ways");
	chk_range_one_on: assert property (on_one == (bridge_one_range != RANGE_OFF))
		else $error("bridge one range and drive disagree");
	chk_range_two_on: assert property (on_two == (bridge_two_range != RANGE_OFF))
		else $error("bridge two range and drive disagree");
	chk_frame_holds: assert property (!frame_select_low [*6] |-> $stable(bridge_one_range))
		else $error("bridge changed inside a frame");
	chk_reverse_gap: assert property ($fell(bridge_one_out_one) |-> !bridge_one_out_two [*8])
		else $error("reversal without off time");
	chk_enable_reset: assert property (device_enable_low_pin [*5] |-> !on_one && !on_two)
		else $error("bridges on while disabled");
	chk_prealarm_flag: assert property ((temp_prealarm_in && run) [*6] |-> !fault_flag_high)
		else $error("pre-alarm not flagged");
	chk_shutdown_off: assert property ((thermal_shutdown_in && run) [*6] |-> !on_one && !on_two)
		else $error("bridges on in shutdown");
	cover property ($fell(bridge_one_out_one) ##[1:40] $rose(bridge_one_out_two));
	cover property (!serial_response_oe_low ##1 serial_response_oe_low);
	cover property (temp_prealarm_in && !fault_flag_high);
endmodule

bind stepper_cmd_port stepper_cmd_port_properties #(
	.ENABLE_SETUP_CYCLES(ENABLE_SETUP_CYCLES),
	.REVERSE_CYCLES(REVERSE_CYCLES)
) chk (
	.clk, .sys_rst, .device_enable_low_pin, .frame_select_low, .temp_prealarm_in,
	.thermal_shutdown_in, .serial_response_oe_low, .fault_flag_high, .bridge_one_out_one,
	.bridge_one_out_two, .bridge_two_out_one, .bridge_two_out_two, .bridge_one_range,
	.bridge_two_range
);

/* bench/host_master_model.sv */
`timescale 1ns/10ps
module host_master_model (
	output logic link_clk,
	output logic frame_select_low,
	output logic serial_command_in,
	input wire logic serial_response_out,
	input wire logic serial_response_oe_low
);
	initial begin
		link_clk = 1'b0;
		frame_select_low = 1'b1;
		serial_command_in = 1'b0;
	end
	// One select, MSB first, sample reply on rise
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		frame_select_low = 1'b0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			serial_command_in = tx[i];
			#62.5;
			link_clk = 1'b1;
			rx = {rx[14:0], serial_response_oe_low ? 1'bx : serial_response_out};
			#62.5;
			link_clk = 1'b0;
		end
		#150;
		// Released line flips so a stale bit cannot pass
		serial_command_in = ~serial_command_in;
		frame_select_low = 1'b1;
	endtask
endmodule

/* bench/stepper_driver_serial_command_port_tb_top.sv */
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module stepper_driver_serial_command_port_tb_top;
	import stepper_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, device_enable_low_pin = 1'b0;
	logic temp_prealarm_in = 1'b0, thermal_shutdown_in = 1'b0;
	logic [1:0] open_load_in = 2'h0;
	logic [3:0] short_supply_in = 4'h0, short_ground_in = 4'h0;
	logic link_clk, frame_select_low, serial_command_in, serial_response_out;
	logic serial_response_oe_low, fault_flag_high, bridge_one_out_one, bridge_one_out_two;
	logic bridge_two_out_one, bridge_two_out_two;
	logic [1:0] bridge_one_range, bridge_two_range;
	logic [7:0] drive_seen;
	logic [5:0] op = 6'h3f;
	logic taken = 1'b0;
	int compares = 0, n_mismatch = 0, cycles = 0;
	localparam logic [7:0] FULL_STEP [4] = '{8'h1b, 8'h13, 8'h12, 8'h1a};
	localparam int BAD_LEN [3] = '{1, 7, 12};
	// Error code above open, supply and ground inputs
	localparam logic [11:0] FLT [5] = '{12'h500, 12'h700, 12'h440, 12'h902, 12'h808};

	always #2 clk = ~clk;
	assign drive_seen = {bridge_one_out_one, bridge_one_out_two, bridge_two_out_one,
		bridge_two_out_two, bridge_one_range, bridge_two_range};

	stepper_cmd_port #(.ENABLE_SETUP_CYCLES(20), .REVERSE_CYCLES(16)) uut (
		.clk, .sys_rst, .device_enable_low_pin, .link_clk, .frame_select_low, .serial_command_in,
		.serial_response_out, .serial_response_oe_low, .open_load_in, .short_supply_in,
		.short_ground_in, .temp_prealarm_in, .thermal_shutdown_in, .fault_flag_high,
		.bridge_one_out_one, .bridge_one_out_two, .bridge_two_out_one, .bridge_two_out_two,
		.bridge_one_range, .bridge_two_range
	);
	host_master_model host (
		.link_clk, .frame_select_low, .serial_command_in, .serial_response_out,
		.serial_response_oe_low
	);
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_drive(input logic [5:0] c);
		logic on1, on2;
		on1 = c[5:4] != RANGE_OFF;
		on2 = c[2:1] != RANGE_OFF;
		return {on1 & c[3], on1 & ~c[3], on2 & c[0], on2 & ~c[0], c[5:4], c[2:1]};
	endfunction

	function automatic logic [15:0] exp_rx(input logic [7:0] r, input logic [15:0] tx, input int n);
		logic [23:0] all;
		all = {r, 16'(tx << (16 - n))};
		return 16'(all >> (24 - n));
	endfunction

	task automatic report_and_stop();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic send(input logic [15:0] tx, input int n, input logic [1:0] err, input bit ok);
		logic [15:0] rx;
		host.xfer(tx, n, rx);
		`CHECK("response", exp_rx(taken ? {err, op} : RESP_STANDBY, tx, n), rx)
		if (ok) begin
			op = tx[5:0];
			taken = 1'b1;
		end
		// Covers sync lag plus the shortened reversal
		repeat (80) @(posedge clk);
		`CHECK("drive", exp_drive(op), drive_seen)
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(76));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (40) @(posedge clk);
		for (int i = 0; i < 8; i++)
			send({8'h00, FULL_STEP[i % 4] | 8'($urandom) & 8'hc0}, 8, 2'h3, 1'b1);
		repeat (6) send({8'h00, 8'($urandom)}, 8, 2'h3, 1'b1);
		for (int i = 0; i < 3; i++)
			send(16'($urandom), BAD_LEN[i], 2'h3, 1'b0);
		send(16'($urandom), 16, 2'h3, 1'b1);
		for (int i = 0; i < 5; i++) begin
			{open_load_in, short_supply_in, short_ground_in} <= FLT[i][9:0];
			repeat (10) @(posedge clk);
			{open_load_in, short_supply_in, short_ground_in} <= 10'h000;
			repeat (10) @(posedge clk);
			`CHECK("flag", FLT[i][11], fault_flag_high)
			send({8'h00, 8'($urandom)}, 8, FLT[i][11:10], 1'b1);
		end
		send({8'h00, 8'($urandom)}, 8, 2'h3, 1'b1);
		temp_prealarm_in <= 1'b1;
		repeat (10) @(posedge clk);
		`CHECK("flag", 1'b0, fault_flag_high)
		send({8'h00, 8'($urandom)}, 8, 2'h0, 1'b1);
		temp_prealarm_in <= 1'b0;
		thermal_shutdown_in <= 1'b1;
		op = 6'h3f;
		repeat (10) @(posedge clk);
		send({8'h00, 8'($urandom)}, 8, 2'h0, 1'b0);
		thermal_shutdown_in <= 1'b0;
		repeat (10) @(posedge clk);
		send({8'h00, 8'($urandom)}, 8, 2'h3, 1'b1);
		device_enable_low_pin <= 1'b1;
		repeat (10) @(posedge clk);
		`CHECK("drive", 8'h0f, drive_seen)
		device_enable_low_pin <= 1'b0;
		taken = 1'b0;
		op = 6'h3f;
		repeat (40) @(posedge clk);
		send({8'h00, 8'($urandom)}, 8, 2'h3, 1'b1);
		report_and_stop();
	end
endmodule
